// ### core/chg_sup_pkg.sv
package chg_sup_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SLOW_HZ = 32768;
  // slow-domain tick divider derived from the 50 MHz clock
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;
  // watchdog periods in seconds, upper bound values
  localparam int unsigned WD_USB_S = 336;
  localparam int unsigned WD_OTHER_S = 855;
  localparam int unsigned WD_USB_LONG_S = 672;
  localparam int unsigned WD_OTHER_LONG_S = 1709;
  localparam int unsigned FAULT_MS = 2500;
  localparam int unsigned FAULT_TICKS = FAULT_MS * SLOW_HZ / 1000;
  localparam int unsigned PWM_HZ = 128;
  localparam int unsigned PWM_STEPS = 255;
  localparam int unsigned PWM_TICK = SLOW_HZ / (PWM_HZ * (PWM_STEPS + 1));
  localparam logic [6:0] WDT_RESET = 7'h00;
  localparam logic [3:0] ICHG_RESET = 4'h0;
  localparam logic [5:0] VREG_RESET = 6'h00;
  localparam logic [3:0] ILIM_RESET = 4'h0;
  localparam logic [5:0] VLIM_RESET = 6'h00;
  typedef enum logic [2:0] {
    SRC_NONE = 3'h1,
    SRC_USB = 3'h2,
    SRC_AUX = 3'h4
  } src_e;
endpackage

// ### core/charger_supervisor_control.sv
// Operation
// RULE_01 - gate charging outside temperature window, disable bit
// RULE_02 - monitor runs with source, interrupt on crossings
// RULE_03 - hardware watchdog six or fourteen minutes
// RULE_04 - long option doubles hardware watchdog periods
// RULE_05 - no source dependency uses other-source period
// RULE_06 - software watchdog uses seven-bit seconds field
// RULE_07 - software writes switch to software control
// RULE_08 - clamp current and voltage to limits
// RULE_09 - lock bit freezes limits until power loss
// RULE_10 - power-on reset clears limits and lock
// RULE_11 - battery removal flags host, ends charging
// RULE_12 - presence detector active charging, active, sleep
// RULE_13 - hardware mode led only while charging
// RULE_14 - software led control, 128 Hz PWM, 255 steps
// RULE_15 - led pulldown when disabled, on after reset
// RULE_16 - boost enabled by boost select field
// RULE_17 - vbus short stops boost, raises interrupt
// RULE_18 - port type detect polarity selectable
// RULE_19 - active-low aux enable, active-low aux status
// RULE_20 - source priority by presence and port type
// RULE_21 - fault 2.5 s moves to lower charger once
// RULE_22 - single charger kept, watchdog ends charging
// RULE_23 - watchdog expiry terminates, interrupts, resets group
// RULE_24 - timers derived from 32 kHz slow tick
`timescale 1ns/10ps
`default_nettype none
module charger_supervisor_control #(
  parameter int unsigned SLOW_DIV_P = chg_sup_pkg::SLOW_DIV,
  parameter int unsigned FAULT_TICKS_P = chg_sup_pkg::FAULT_TICKS,
  parameter int unsigned SEC_TICKS_P = chg_sup_pkg::SLOW_HZ
) (
  // clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic power_on_reset_n,
  // nonvolatile options
  input wire logic nv_temp_gate_dis,
  input wire logic nv_wd_long,
  input wire logic nv_src_dep,
  input wire logic nv_det_invert,
  // sensed conditions
  input wire logic vbus_det,
  input wire logic wall_charger_input,
  input wire logic temp_in_window,
  input wire logic battery_sense_input,
  input wire logic pwr_active_or_sleep,
  input wire logic port_type_detect_n,
  input wire logic usb_fault,
  input wire logic vbus_short,
  input wire logic aux_charger_status_n,
  // software control: one-cycle write strobes with data, then held level settings
  input wire logic watchdog_restart_bit,
  input wire logic wdt_wr,
  input wire logic [6:0] watchdog_timeout_field,
  input wire logic ichg_wr,
  input wire logic [3:0] charge_current_setting,
  input wire logic vreg_wr,
  input wire logic [5:0] charge_voltage_setting,
  input wire logic lim_wr,
  input wire logic [3:0] lim_current,
  input wire logic [5:0] lim_voltage,
  input wire logic lock_limit_wr,
  input wire logic temp_irq_mask,
  input wire logic boost_select_field,
  input wire logic led_sw_en,
  input wire logic [7:0] led_duty,
  input wire logic [1:0] led_supply_sel,
  input wire logic [1:0] led_level_sel,
  input wire logic led_pulldown_sel,
  // outputs
  output logic usb_charge_en,
  output logic aux_charger_enable_n,
  output logic charge_gated,
  output logic sw_mode,
  output logic [3:0] ichg_eff,
  output logic [5:0] vreg_eff,
  output logic limits_locked,
  output logic temp_irq,
  output logic batt_removed,
  output logic wd_expired_irq,
  output logic boost_on,
  output logic vbus_short_irq,
  output logic led_drive,
  output logic [1:0] led_supply,
  output logic [1:0] led_level,
  output logic led_pulldown
);
  import chg_sup_pkg::*;

  logic [15:0] div_reg;
  logic tick_reg;
  logic [15:0] sec_cnt_reg;
  logic sec_tick_reg;
  logic [10:0] wd_cnt_reg;
  logic [16:0] flt_cnt_reg;
  logic [7:0] pwm_cnt_reg;
  logic [3:0] pwm_pre_reg;
  logic [6:0] wdt_reg;
  logic [3:0] ichg_reg;
  logic [5:0] vreg_reg;
  logic [3:0] ilim_reg;
  logic [5:0] vlim_reg;
  logic lock_reg;
  logic temp_prev_reg;
  logic switched_reg;
  logic terminated_reg;
  src_e src_reg;
  src_e src_next;
  logic usb_pref;
  logic both;
  logic cur_fault;
  logic [10:0] wd_limit;
  logic presence_on;
  logic removed_now;
  logic charging;

  // slow tick emulating the always-on 32 kHz domain
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == 16'(SLOW_DIV_P - 1)) begin // RULE_24
      div_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sec_cnt_reg <= '0;
      sec_tick_reg <= 1'b0;
    end else begin
      sec_tick_reg <= 1'b0;
      if (tick_reg) begin
        if (sec_cnt_reg == 16'(SEC_TICKS_P - 1)) begin
          sec_cnt_reg <= '0;
          sec_tick_reg <= 1'b1;
        end else begin
          sec_cnt_reg <= sec_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // source selection
  assign usb_pref = port_type_detect_n ^ nv_det_invert; // RULE_18
  assign both = vbus_det && wall_charger_input;
  assign cur_fault = (src_reg == SRC_USB) ? usb_fault : aux_charger_status_n;
  assign charging = (src_reg != SRC_NONE) && !charge_gated && !terminated_reg;

  always_comb begin
    src_next = SRC_NONE;
    if (vbus_det && !wall_charger_input) begin // RULE_20
      src_next = SRC_USB;
    end else if (wall_charger_input && !vbus_det) begin
      src_next = SRC_AUX;
    end else if (both) begin
      src_next = usb_pref ? SRC_USB : SRC_AUX; // RULE_20
      // once demoted, stay on the lower charger to avoid ping-pong
      if (switched_reg) begin // RULE_21
        src_next = usb_pref ? SRC_AUX : SRC_USB;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      src_reg <= SRC_NONE;
      switched_reg <= 1'b0;
      flt_cnt_reg <= '0;
    end else begin
      src_reg <= src_next;
      if (!both) begin
        switched_reg <= 1'b0;
      end
      if (!cur_fault || sw_mode || src_reg == SRC_NONE) begin
        flt_cnt_reg <= '0;
      end else if (tick_reg && flt_cnt_reg != 17'(FAULT_TICKS_P)) begin
        flt_cnt_reg <= flt_cnt_reg + 17'h00001;
      end
      // single charger: fault never disables it
      if (both && !switched_reg && flt_cnt_reg == 17'(FAULT_TICKS_P)) begin // RULE_21 RULE_22
        switched_reg <= 1'b1;
        flt_cnt_reg <= '0;
      end
    end
  end

  // watchdog period select
  always_comb begin
    if (sw_mode) begin
      wd_limit = {4'h0, wdt_reg}; // RULE_06
    end else if (nv_src_dep && src_reg == SRC_USB && usb_pref) begin // RULE_03 RULE_05
      wd_limit = nv_wd_long ? 11'(WD_USB_LONG_S) : 11'(WD_USB_S); // RULE_04
    end else begin
      wd_limit = nv_wd_long ? 11'(WD_OTHER_LONG_S) : 11'(WD_OTHER_S); // RULE_04
    end
  end

  // software writes to control bits hand control to software
  always_ff @(posedge mclk) begin
    if (rst) begin
      sw_mode <= 1'b0;
      wdt_reg <= WDT_RESET;
      ichg_reg <= ICHG_RESET;
      vreg_reg <= VREG_RESET;
    end else if (wd_expired_irq) begin // RULE_23
      sw_mode <= 1'b0;
      wdt_reg <= WDT_RESET;
      ichg_reg <= ICHG_RESET;
      vreg_reg <= VREG_RESET;
    end else begin
      if (watchdog_restart_bit || wdt_wr || ichg_wr || vreg_wr) begin // RULE_07
        sw_mode <= 1'b1;
      end
      if (wdt_wr) begin
        wdt_reg <= watchdog_timeout_field;
      end
      if (ichg_wr) begin
        ichg_reg <= charge_current_setting;
      end
      if (vreg_wr) begin
        vreg_reg <= charge_voltage_setting;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wd_cnt_reg <= '0;
      wd_expired_irq <= 1'b0;
      terminated_reg <= 1'b0;
    end else begin
      wd_expired_irq <= 1'b0;
      if (src_reg == SRC_NONE) begin
        terminated_reg <= 1'b0;
        wd_cnt_reg <= '0;
      end else if (removed_now) begin // RULE_11
        terminated_reg <= 1'b1;
      end else if (watchdog_restart_bit || wdt_wr) begin
        wd_cnt_reg <= '0;
      end else if (!terminated_reg && sec_tick_reg) begin
        if (wd_cnt_reg >= wd_limit - 11'h001) begin
          wd_expired_irq <= 1'b1; // RULE_23
          terminated_reg <= 1'b1;
          wd_cnt_reg <= '0;
        end else begin
          wd_cnt_reg <= wd_cnt_reg + 11'h001;
        end
      end
    end
  end

  // limits survive soft reset, cleared only by power-on reset
  always_ff @(posedge mclk) begin
    if (!power_on_reset_n) begin // RULE_10
      ilim_reg <= ILIM_RESET;
      vlim_reg <= VLIM_RESET;
      lock_reg <= 1'b0;
    end else begin
      if (lim_wr && !lock_reg) begin // RULE_09
        ilim_reg <= lim_current;
        vlim_reg <= lim_voltage;
      end
      if (lock_limit_wr) begin
        lock_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ichg_eff <= '0;
      vreg_eff <= '0;
      limits_locked <= 1'b0;
    end else begin
      ichg_eff <= (ichg_reg > ilim_reg) ? ilim_reg : ichg_reg; // RULE_08
      vreg_eff <= (vreg_reg > vlim_reg) ? vlim_reg : vreg_reg; // RULE_08
      limits_locked <= lock_reg;
    end
  end

  // temperature gate and crossing interrupt
  always_ff @(posedge mclk) begin
    if (rst) begin
      temp_prev_reg <= 1'b1;
      temp_irq <= 1'b0;
      charge_gated <= 1'b0;
    end else begin
      temp_irq <= 1'b0;
      charge_gated <= 1'b0;
      if (vbus_det || wall_charger_input) begin // RULE_02
        temp_prev_reg <= temp_in_window;
        if (temp_prev_reg != temp_in_window && !temp_irq_mask) begin
          temp_irq <= 1'b1; // RULE_02
        end
        charge_gated <= !temp_in_window && !nv_temp_gate_dis; // RULE_01
      end
    end
  end

  // battery presence
  assign presence_on = (src_reg != SRC_NONE) || pwr_active_or_sleep; // RULE_12
  assign removed_now = presence_on && battery_sense_input;

  always_ff @(posedge mclk) begin
    if (rst) begin
      batt_removed <= 1'b0;
    end else begin
      batt_removed <= removed_now; // RULE_11
    end
  end

  // charger enables
  always_ff @(posedge mclk) begin
    if (rst) begin
      usb_charge_en <= 1'b0;
      aux_charger_enable_n <= 1'b1;
    end else begin
      usb_charge_en <= charging && src_reg == SRC_USB && !boost_on;
      aux_charger_enable_n <= !(charging && src_reg == SRC_AUX); // RULE_19
    end
  end

  // boost with short-circuit shutdown; retries once the short has cleared
  always_ff @(posedge mclk) begin
    if (rst) begin
      boost_on <= 1'b0;
      vbus_short_irq <= 1'b0;
    end else begin
      vbus_short_irq <= 1'b0;
      if (boost_on && vbus_short) begin // RULE_17
        boost_on <= 1'b0;
        vbus_short_irq <= 1'b1;
      end else if (!boost_select_field) begin // RULE_16
        boost_on <= 1'b0;
      end else if (!vbus_short && !vbus_short_irq && !boost_on) begin
        boost_on <= 1'b1;
      end
    end
  end

  // led pwm: 255-step duty over a 256-slot frame
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwm_pre_reg <= '0;
      pwm_cnt_reg <= '0;
    end else if (tick_reg) begin
      if (pwm_pre_reg == 4'(PWM_TICK - 1) || PWM_TICK <= 1) begin // RULE_14
        pwm_pre_reg <= '0;
        pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
      end else begin
        pwm_pre_reg <= pwm_pre_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      led_drive <= 1'b0;
      led_supply <= 2'h0;
      led_level <= 2'h0;
      led_pulldown <= 1'b1; // RULE_15
    end else begin
      if (led_sw_en) begin
        led_drive <= pwm_cnt_reg < led_duty; // RULE_14
        led_supply <= led_supply_sel;
        led_level <= led_level_sel;
        led_pulldown <= 1'b0;
      end else begin
        // status line low means the aux charger is really charging
        led_drive <= !sw_mode && charging &&
          ((src_reg == SRC_USB && !usb_fault) ||
           (src_reg == SRC_AUX && !aux_charger_status_n)); // RULE_13
        led_supply <= (src_reg == SRC_AUX) ? 2'h1 : 2'h0;
        led_level <= 2'h0;
        led_pulldown <= led_pulldown_sel && !led_drive; // RULE_15
      end
    end
  end

  a_lock_holds: assert property (@(posedge mclk) disable iff (!power_on_reset_n)
    lock_reg && lim_wr |=> $stable(ilim_reg) && $stable(vlim_reg)) // RULE_09
    else $error("limits changed while locked");
  a_clamp_current: assert property (@(posedge mclk) disable iff (rst)
    ##1 ichg_eff <= $past(ilim_reg)) // RULE_08
    else $error("current above limit");
  a_sw_switch: assert property (@(posedge mclk) disable iff (rst)
    (watchdog_restart_bit || wdt_wr || ichg_wr || vreg_wr) && !wd_expired_irq |=> sw_mode) // RULE_07
    else $error("no switch to software control");
  a_short_stop: assert property (@(posedge mclk) disable iff (rst)
    boost_on && vbus_short |=> !boost_on && vbus_short_irq) // RULE_17
    else $error("boost not stopped on short");
  a_aux_enable: assert property (@(posedge mclk) disable iff (rst)
    !aux_charger_enable_n |-> $past(src_reg) == SRC_AUX) // RULE_19
    else $error("aux enabled without aux source");
  a_removal_flag: assert property (@(posedge mclk) disable iff (rst)
    presence_on && battery_sense_input |=> batt_removed) // RULE_11
    else $error("removal not flagged");
  a_gate_temp: assert property (@(posedge mclk) disable iff (rst)
    vbus_det && !temp_in_window && !nv_temp_gate_dis |=> charge_gated) // RULE_01
    else $error("charging not gated");
  a_usb_prio: assert property (@(posedge mclk) disable iff (rst)
    vbus_det && !wall_charger_input |=> src_reg == SRC_USB) // RULE_20
    else $error("usb not chosen");
  a_wd_period: assert property (@(posedge mclk) disable iff (rst)
    !sw_mode && !nv_src_dep |-> wd_limit >= 11'(WD_OTHER_S)) // RULE_05
    else $error("wrong hardware watchdog period");
endmodule // charger_supervisor_control
`default_nettype wire

// ### dv/aux_charger_model.sv
`timescale 1ns/10ps
`default_nettype none
module aux_charger_model (
  // link to the supervisor
  input wire logic aux_charger_enable_n,
  input wire logic fault,
  output logic aux_charger_status_n
);
  // status is pulled low only while enabled and healthy, else pull-up wins
  assign aux_charger_status_n = aux_charger_enable_n | fault;
endmodule // aux_charger_model
`default_nettype wire

// ### dv/charger_supervisor_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module charger_supervisor_control_bench;
  import chg_sup_pkg::*;
  logic mclk, rst, power_on_reset_n, nv_temp_gate_dis, nv_wd_long, nv_src_dep, nv_det_invert;
  logic vbus_det, wall_charger_input, temp_in_window, battery_sense_input, pwr_active_or_sleep;
  logic port_type_detect_n, usb_fault, vbus_short, aux_charger_status_n, aux_fault;
  logic watchdog_restart_bit, wdt_wr, ichg_wr, vreg_wr, lim_wr, lock_limit_wr;
  logic [6:0] watchdog_timeout_field;
  logic [3:0] charge_current_setting, lim_current;
  logic [5:0] charge_voltage_setting, lim_voltage;
  logic temp_irq_mask, boost_select_field, led_sw_en, led_pulldown_sel;
  logic [7:0] led_duty;
  logic [1:0] led_supply_sel, led_level_sel, led_supply, led_level;
  logic usb_charge_en, aux_charger_enable_n, charge_gated, sw_mode, limits_locked, temp_irq;
  logic batt_removed, wd_expired_irq, boost_on, vbus_short_irq, led_drive, led_pulldown;
  logic [3:0] ichg_eff;
  logic [5:0] vreg_eff;
  int fail_count = 0;
  int comparisons = 0;
  int tnum = 0;
  logic [31:0] sq[$];
  logic [2:0] iq[$];
  event stat_ev;
  event lvl_ev;
  logic [63:0] lq[$];
  logic [15:0] duty_cnt = 16'h0000;
  wire logic [31:0] lvl = {vreg_eff, led_supply, led_level, 6'h0, duty_cnt};
  wire logic [15:0] stat = {usb_charge_en, aux_charger_enable_n, charge_gated, sw_mode,
    limits_locked, batt_removed, boost_on, led_pulldown, led_drive, 3'h0, ichg_eff};

  // short counts: one slow tick is two clocks, one second is eight
  charger_supervisor_control #(.SLOW_DIV_P(2), .SEC_TICKS_P(4), .FAULT_TICKS_P(5)) DUT (
    .mclk, .rst, .power_on_reset_n, .nv_temp_gate_dis, .nv_wd_long, .nv_src_dep,
    .nv_det_invert, .vbus_det, .wall_charger_input, .temp_in_window, .battery_sense_input,
    .pwr_active_or_sleep, .port_type_detect_n, .usb_fault, .vbus_short, .aux_charger_status_n,
    .watchdog_restart_bit, .wdt_wr, .watchdog_timeout_field, .ichg_wr, .charge_current_setting,
    .vreg_wr, .charge_voltage_setting, .lim_wr, .lim_current, .lim_voltage, .lock_limit_wr,
    .temp_irq_mask, .boost_select_field, .led_sw_en, .led_duty, .led_supply_sel,
    .led_level_sel, .led_pulldown_sel, .usb_charge_en, .aux_charger_enable_n, .charge_gated,
    .sw_mode, .ichg_eff, .vreg_eff, .limits_locked, .temp_irq, .batt_removed,
    .wd_expired_irq, .boost_on, .vbus_short_irq, .led_drive, .led_supply, .led_level,
    .led_pulldown);
  aux_charger_model far_end (.aux_charger_enable_n, .fault(aux_fault), .aux_charger_status_n);

  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
  endtask

  task automatic end_test();
    tnum++;
    $display("test %0d done", tnum);
  endtask

  task automatic compare_stat(input logic [15:0] m, e);
    comparisons++;
    if ((stat & m) !== (e & m)) begin
      fail_count++;
      $display("BAD %0t status %h want %h", $time, stat & m, e & m);
    end
  endtask

  task automatic compare_irq(input logic [2:0] e, input logic [2:0] got);
    comparisons++;
    if (e !== got) begin
      fail_count++;
      $display("BAD %0t pulse %b want %b", $time, got, e);
    end
  endtask

  task automatic note_stat(input logic [15:0] m, e);
    sq.push_back({m, e});
    ->stat_ev;
  endtask

  task automatic compare_lvl(input logic [31:0] m, e);
    comparisons++;
    if ((lvl & m) !== (e & m)) begin
      fail_count++;
      $display("BAD %0t level %h want %h", $time, lvl & m, e & m);
    end
  endtask

  task automatic note_lvl(input logic [31:0] m, e);
    lq.push_back({m, e});
    ->lvl_ev;
  endtask

  // bounded wait for a level, then the note is judged by the monitor
  task automatic wait_stat(input logic [15:0] m, e, input int lim);
    int k;
    k = 0;
    while ((stat & m) !== (e & m) && k < lim) begin
      cyc(1);
      k++;
    end
    if ((stat & m) !== (e & m)) begin
      fail_count++;
      $display("BAD %0t status wait ran out", $time);
      stop_test();
    end
    note_stat(m, e);
  endtask

  task automatic drain(input int lim);
    int k;
    k = 0;
    while (iq.size() != 0 && k < lim) begin
      cyc(1);
      k++;
    end
    if (iq.size() != 0) begin
      fail_count++;
      $display("BAD %0t pulse never came", $time);
      stop_test();
    end
  endtask

  // several notes may land in one time step: judge them all
  always @(stat_ev) begin
    logic [31:0] n;
    while (sq.size() != 0) begin
      n = sq.pop_front();
      compare_stat(n[31:16], n[15:0]);
    end
  end

  always @(lvl_ev) begin
    logic [63:0] w;
    while (lq.size() != 0) begin
      w = lq.pop_front();
      compare_lvl(w[63:32], w[31:0]);
    end
  end

  // pulses are looked at mid-cycle, where they are settled
  always @(negedge mclk) begin
    if ((temp_irq | vbus_short_irq | wd_expired_irq) === 1'b1) begin
      if (iq.size() == 0) compare_irq(3'h0, {temp_irq, vbus_short_irq, wd_expired_irq});
      else compare_irq(iq.pop_front(), {temp_irq, vbus_short_irq, wd_expired_irq});
    end
  end

  initial begin
    logic u, a, p;
    logic [3:0] d;
    logic [5:0] v;
    {rst, power_on_reset_n, nv_temp_gate_dis, nv_wd_long, nv_src_dep, nv_det_invert} = 6'h23;
    {vbus_det, wall_charger_input, temp_in_window, battery_sense_input} = 4'h2;
    {pwr_active_or_sleep, port_type_detect_n, usb_fault, vbus_short, aux_fault} = 5'h10;
    {watchdog_restart_bit, wdt_wr, ichg_wr, vreg_wr, lim_wr, lock_limit_wr} = 6'h00;
    {watchdog_timeout_field, charge_current_setting, charge_voltage_setting} = 17'h00000;
    {lim_current, lim_voltage, temp_irq_mask, boost_select_field, led_sw_en} = 13'h0000;
    {led_pulldown_sel, led_duty, led_supply_sel, led_level_sel} = 13'h1000;
    void'($urandom(41377));
    cyc(6);
    note_stat(16'hFFFF, 16'h4100);
    rst = 0;
    power_on_reset_n = 1;
    end_test();
    for (int i = 0; i < 8; i++) begin
      {u, a, p} = i[2:0];
      led_duty = 8'($urandom);
      nv_det_invert = 1'($urandom);
      port_type_detect_n = p ^ nv_det_invert;
      vbus_det = u;
      wall_charger_input = a;
      wait_stat(16'hC080, {u & (~a | p), ~(a & ~(u & p)), 6'h0, (u | a), 7'h0}, 20);
      {vbus_det, wall_charger_input} = 2'h0;
      cyc(3);
    end
    end_test();
    {vbus_det, usb_fault} = 2'h3;
    cyc(40);
    note_stat(16'hC000, 16'hC000);
    {wall_charger_input, port_type_detect_n, nv_det_invert} = 3'h6;
    cyc(4);
    usb_fault = 1;
    wait_stat(16'hC000, 16'h0000, 40);
    aux_fault = 1;
    cyc(40);
    note_stat(16'hC000, 16'h0000);
    {vbus_det, wall_charger_input, usb_fault, aux_fault} = 4'h0;
    cyc(3);
    end_test();
    vbus_det = 1;
    iq.push_back(3'h4);
    iq.push_back(3'h4);
    temp_in_window = 0;
    wait_stat(16'h2000, 16'h2000, 20);
    temp_in_window = 1;
    wait_stat(16'h2000, 16'h0000, 20);
    drain(10);
    {temp_irq_mask, nv_temp_gate_dis, temp_in_window} = 3'h6;
    cyc(8);
    note_stat(16'h2000, 16'h0000);
    {temp_irq_mask, nv_temp_gate_dis, temp_in_window} = 3'h5;
    cyc(4);
    end_test();
    {lim_current, lim_voltage} = 10'h1A0;
    pulse(lim_wr);
    pulse(lock_limit_wr);
    wait_stat(16'h1800, 16'h0800, 10);
    lim_current = 4'hF;
    pulse(lim_wr);
    pulse(watchdog_restart_bit);
    note_stat(16'h1000, 16'h1000);
    watchdog_timeout_field = 7'h7F;
    pulse(wdt_wr);
    for (int i = 0; i < 6; i++) begin
      d = 4'($urandom);
      charge_current_setting = d;
      pulse(ichg_wr);
      cyc(2);
      note_stat(16'h180F, {4'h9, 8'h80, (d < 4'h6) ? d : 4'h6});
    end
    v = 6'($urandom);
    charge_voltage_setting = v;
    pulse(vreg_wr);
    cyc(2);
    note_lvl(32'hFC000000, {(v > 6'h20) ? 6'h20 : v, 26'h0});
    power_on_reset_n = 0;
    cyc(2);
    power_on_reset_n = 1;
    wait_stat(16'h080F, 16'h0000, 10);
    note_lvl(32'hFC000000, 32'h00000000);
    end_test();
    watchdog_timeout_field = 7'h02;
    pulse(wdt_wr);
    iq.push_back(3'h1);
    cyc(8);
    note_stat(16'h1000, 16'h1000);
    drain(20);
    cyc(2);
    note_stat(16'h9000, 16'h0000);
    vbus_det = 0;
    end_test();
    boost_select_field = 1;
    wait_stat(16'h0200, 16'h0200, 4);
    iq.push_back(3'h2);
    vbus_short = 1;
    wait_stat(16'h0200, 16'h0000, 4);
    drain(4);
    cyc(2);
    note_stat(16'h0200, 16'h0000);
    vbus_short = 0;
    cyc(4);
    note_stat(16'h0200, 16'h0200);
    boost_select_field = 0;
    cyc(2);
    boost_select_field = 1;
    wait_stat(16'h0200, 16'h0200, 4);
    boost_select_field = 0;
    end_test();
    led_sw_en = 1;
    {led_supply_sel, led_level_sel} = 4'($urandom);
    cyc(2);
    note_stat(16'h0100, 16'h0000);
    duty_cnt = 16'h0000;
    repeat (512) begin
      cyc(1);
      duty_cnt = duty_cnt + 16'(led_drive);
    end
    // one frame is 256 slots of two clocks each
    note_lvl(32'h03C0FFFF,
      {6'h0, led_supply_sel, led_level_sel, 13'h0, led_duty, 1'b0});
    led_sw_en = 0;
    cyc(2);
    note_stat(16'h0180, 16'h0100);
    led_pulldown_sel = 0;
    cyc(2);
    note_stat(16'h0100, 16'h0000);
    end_test();
    {nv_src_dep, nv_wd_long} = 2'h1;
    {vbus_det, pwr_active_or_sleep} = 2'h3;
    wait_stat(16'h8000, 16'h8000, 20);
    battery_sense_input = 1;
    wait_stat(16'h8400, 16'h0400, 20);
    end_test();
    cyc(2);
    comparisons++;
    if (iq.size() != 0) begin
      fail_count++;
      $display("BAD %0t pulses missing", $time);
    end
    stop_test();
  end
endmodule // charger_supervisor_control_bench
`default_nettype wire
